/* rtl/acdpc_ctrl.sv */
`default_nettype none

module acdpc_ctrl (
  input  wire logic                          CLK_IN,
  input  wire logic                          SYS_RST_IN,
  input  wire logic                          SYNC_IN,
  input  wire logic                          POWERDOWN_PIN_IN,
  input  wire logic                          REF_SEL_HIGH_IN,
  input  wire logic                          REG_WR_IN,
  input  wire logic                          REG_RD_IN,
  input  wire logic [acdpc_pkg::ADDR_W-1:0]  REG_ADDR_IN,
  input  wire logic [acdpc_pkg::DATA_W-1:0]  REG_WDATA_IN,
  output logic      [acdpc_pkg::DATA_W-1:0]  REG_RDATA_OUT,
  output logic                               REG_RVALID_OUT,
  output logic                               SAMPLE_STB_OUT,
  output logic                               DIV_CLK_OUT,
  output logic                               OUT_DRV_EN_OUT,
  output logic                               REF_PWR_OUT,
  output logic                               BIAS_PWR_OUT,
  output logic                               CLK_PWR_OUT,
  output logic                               INT_REF_EN_OUT,
  output logic                               READY_OUT,
  output logic                               DUTY_STABILISER_LOCK_OUT
);
  import acdpc_pkg::*;

  typedef struct packed {
    logic [7:0]          pm;
    logic [7:0]          sync;
    logic                armed;
    logic [7:0]          cdiv;
    acdpc_pstate_t       ps;
    logic [PD_CNT_W-1:0] dur;
    logic [PD_CNT_W-1:0] wake;
    logic [RELOCK_W-1:0] relock;
    logic                sync_d;
    logic [7:0]          rdata;
    logic                rvalid;
    logic                drv_en;
    logic                ref_pwr;
    logic                bias_pwr;
    logic                clk_pwr;
    logic                int_ref;
    logic                ready;
    logic                dcs_lock;
  } acdpc_ctrl_t;

  acdpc_ctrl_t st_r;
  acdpc_ctrl_t st_nxt;

  logic sync_rise;
  logic sync_ok;
  logic wr_sync;
  logic wr_cdiv;
  logic pd_req;
  logic sb_req;
  logic dcs_act;

  // stabiliser loop only counts as running when the divided rate clears its floor
  function automatic logic dcs_rate_ok(input logic [2:0] m1);
    dcs_rate_ok = CLK_MHZ >= DCS_MIN_MHZ * (int'(m1) + 1);
  endfunction

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  always_comb begin
    // pin is taken on its rising edge against the previous sample; an open pin rests low on its pull-down
    sync_rise = SYNC_IN & ~st_r.sync_d;
    sync_ok   = sync_rise & st_r.sync[SYNC_EN_BIT]
                & (~st_r.sync[SYNC_ONCE_BIT] | st_r.armed);
    wr_sync   = REG_WR_IN && REG_ADDR_IN == ADDR_DIV_SYNC;
    wr_cdiv   = REG_WR_IN && REG_ADDR_IN == ADDR_CLK_DIV;
    pd_req    = POWERDOWN_PIN_IN | (st_r.pm[2:0] == PM_POWERDOWN_PIN);
    sb_req    = st_r.pm[2:0] == PM_STBY;
    dcs_act   = st_r.cdiv[DCS_EN_BIT] & dcs_rate_ok(st_r.cdiv[2:0]);
  end

  // ----------------------------------------------------------------
  // registers and power sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.sync_d = SYNC_IN;

    if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        ADDR_POWER_MODE: st_nxt.pm   = REG_WDATA_IN;
        ADDR_DIV_SYNC:   st_nxt.sync = REG_WDATA_IN & SYNC_WR_MASK;
        ADDR_CLK_DIV:    st_nxt.cdiv = REG_WDATA_IN & CLK_DIV_WR_MASK;
        default:         st_nxt.pm   = st_r.pm;
      endcase
    end

    // a write in the same cycle as a consumed pulse leaves it armed
    if (sync_ok) begin
      st_nxt.armed = 1'b0;
    end
    if (wr_sync) begin
      st_nxt.armed = 1'b1;
    end

    if (REG_RD_IN) begin
      st_nxt.rvalid = 1'b1;
      case (REG_ADDR_IN)
        ADDR_POWER_MODE: st_nxt.rdata = st_r.pm;
        ADDR_DIV_SYNC:   st_nxt.rdata = st_r.sync | ({7'h00, st_r.armed} << SYNC_ARMED_BIT);
        ADDR_CLK_DIV:    st_nxt.rdata = st_r.cdiv;
        default:         st_nxt.rdata = 8'h00;
      endcase
    end

    case (st_r.ps)
      PS_ON: begin
        st_nxt.dur = '0;
        if (pd_req) begin
          st_nxt.ps = PS_POWERDOWN_PIN;
        end else if (sb_req) begin
          st_nxt.ps = PS_STBY;
        end
      end
      PS_POWERDOWN_PIN, PS_STBY: begin
        if (st_r.dur != '1) begin
          st_nxt.dur = st_r.dur + 1'b1;
        end
        if (pd_req) begin
          st_nxt.ps = PS_POWERDOWN_PIN;
        end else if (sb_req) begin
          st_nxt.ps = PS_STBY;
        end else begin
          // recharge time scales with time spent down; standby keeps the
          // reference up so it recovers a fixed factor faster
          st_nxt.ps   = PS_WAKE;
          st_nxt.wake = (st_r.ps == PS_POWERDOWN_PIN) ? (st_r.dur >> WAKE_SHIFT)
                                             : (st_r.dur >> (WAKE_SHIFT + STBY_SHIFT));
        end
      end
      PS_WAKE: begin
        if (pd_req) begin
          st_nxt.ps = PS_POWERDOWN_PIN;
        end else if (sb_req) begin
          st_nxt.ps = PS_STBY;
        end else if (st_r.wake == '0) begin
          st_nxt.ps = PS_ON;
        end else begin
          st_nxt.wake = st_r.wake - 1'b1;
        end
      end
      default: st_nxt.ps = PS_POWERDOWN_PIN;
    endcase

    st_nxt.drv_en   = st_nxt.ps != PS_POWERDOWN_PIN;
    st_nxt.ref_pwr  = st_nxt.ps != PS_POWERDOWN_PIN;
    st_nxt.bias_pwr = st_nxt.ps != PS_POWERDOWN_PIN && st_nxt.ps != PS_STBY;
    st_nxt.clk_pwr  = st_nxt.ps == PS_ON || st_nxt.ps == PS_WAKE;
    st_nxt.ready    = st_nxt.ps == PS_ON;
    st_nxt.int_ref  = st_nxt.ref_pwr & ~REF_SEL_HIGH_IN;

    // any change of divided rate forces the loop to relock
    if (wr_cdiv || st_r.ps == PS_WAKE || !dcs_act) begin
      st_nxt.relock = RELOCK_W'(RELOCK_CYC);
    end else if (st_r.relock != '0) begin
      st_nxt.relock = st_r.relock - 1'b1;
    end
    st_nxt.dcs_lock = dcs_act && st_nxt.relock == '0;
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_r      <= '0;
      st_r.pm   <= POWER_MODE_RST;
      st_r.sync <= DIV_SYNC_RST;
      st_r.cdiv <= CLK_DIV_RST;
      st_r.ps   <= PS_ON;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // divider and outputs
  // ----------------------------------------------------------------
  acdpc_divider u_div (
    .clk_in      (CLK_IN),
    .rst_in      (SYS_RST_IN),
    .run_in      (st_r.clk_pwr),
    .ratio_m1_in (st_r.cdiv[2:0]),
    .sync_in     (sync_ok),
    .dcs_en_in   (dcs_act),
    .tick_out    (SAMPLE_STB_OUT),
    .div_clk_out (DIV_CLK_OUT)
  );

  assign REG_RDATA_OUT            = st_r.rdata;
  assign REG_RVALID_OUT           = st_r.rvalid;
  assign OUT_DRV_EN_OUT           = st_r.drv_en;
  assign REF_PWR_OUT              = st_r.ref_pwr;
  assign BIAS_PWR_OUT             = st_r.bias_pwr;
  assign CLK_PWR_OUT              = st_r.clk_pwr;
  assign INT_REF_EN_OUT           = st_r.int_ref;
  assign READY_OUT                = st_r.ready;
  assign DUTY_STABILISER_LOCK_OUT = st_r.dcs_lock;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_pin_pd_off: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    POWERDOWN_PIN_IN |=> !OUT_DRV_EN_OUT && !CLK_PWR_OUT && !REF_PWR_OUT)
    else $error("power-down pin did not shut drivers, clock and reference");

  a_pd_drv_hiz: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    st_r.ps == PS_POWERDOWN_PIN |-> !OUT_DRV_EN_OUT && !BIAS_PWR_OUT)
    else $error("drivers enabled during power-down");

  a_stby_ref_on: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    st_r.ps == PS_STBY |-> REF_PWR_OUT && !CLK_PWR_OUT && !READY_OUT)
    else $error("standby lost reference or kept clock");

  a_pin_release: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    st_r.ps == PS_POWERDOWN_PIN && !pd_req && !sb_req |=> st_r.ps == PS_WAKE ##1 CLK_PWR_OUT)
    else $error("pin release did not start wake-up");

  a_wake_scaled: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    st_r.ps == PS_POWERDOWN_PIN && !pd_req && !sb_req
      |=> st_r.wake == ($past(st_r.dur) >> WAKE_SHIFT))
    else $error("wake time not scaled from power-down time");

  a_wake_done: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    st_r.ps == PS_WAKE && st_r.wake == '0 && !pd_req && !sb_req |=> READY_OUT)
    else $error("wake-up did not finish on count");

  a_sync_once: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    sync_ok && st_r.sync[SYNC_ONCE_BIT] && !wr_sync |=> !st_r.armed ##1 !sync_ok)
    else $error("one-shot sync accepted twice");

  a_int_ref_sel: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    ##1 INT_REF_EN_OUT |-> !$past(REF_SEL_HIGH_IN) && REF_PWR_OUT)
    else $error("internal reference on with select pin high");

  a_read_answer: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    REG_RD_IN && REG_ADDR_IN == ADDR_CLK_DIV && !REG_WR_IN
      |=> REG_RVALID_OUT && REG_RDATA_OUT == $past(st_r.cdiv))
    else $error("register read answered wrongly");

  a_dcs_floor: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    st_r.cdiv[2:0] == 3'h7 |=> !DUTY_STABILISER_LOCK_OUT)
    else $error("stabiliser locked below its rate floor");

endmodule : acdpc_ctrl

`default_nettype wire

/* rtl/acdpc_pkg.sv */
`default_nettype none

package acdpc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 8;
  localparam logic [11:0] ADDR_POWER_MODE = 12'h100;
  localparam logic [11:0] ADDR_DIV_SYNC   = 12'h109;
  localparam logic [11:0] ADDR_CLK_DIV    = 12'h10b;

  localparam logic [7:0]  POWER_MODE_RST  = 8'h00;
  localparam logic [7:0]  DIV_SYNC_RST    = 8'h00;
  localparam logic [7:0]  CLK_DIV_RST     = 8'h10;

  // power mode field, bits [2:0]
  localparam logic [2:0]  PM_NORMAL       = 3'h0;
  localparam logic [2:0]  PM_POWERDOWN_PIN         = 3'h1;
  localparam logic [2:0]  PM_STBY         = 3'h2;

  // divider sync register bits
  localparam int          SYNC_EN_BIT     = 0;
  localparam int          SYNC_ONCE_BIT   = 1;
  localparam int          SYNC_ARMED_BIT  = 3;
  localparam logic [7:0]  SYNC_WR_MASK    = 8'h03;

  // clock divide register: [2:0] ratio minus one, bit 4 stabiliser enable
  localparam int          DCS_EN_BIT      = 4;
  localparam logic [7:0]  CLK_DIV_WR_MASK = 8'h17;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ         = 125;
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          DCS_MIN_MHZ     = 20;
  localparam int          RELOCK_MAX_NS   = 5000;
  localparam int          RELOCK_CYC      = (RELOCK_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RELOCK_W        = 10;
  localparam int          PD_CNT_W        = 16;
  localparam int          WAKE_SHIFT      = 4;
  localparam int          STBY_SHIFT      = 2;

  typedef enum logic [1:0] {PS_ON, PS_POWERDOWN_PIN, PS_STBY, PS_WAKE} acdpc_pstate_t;

endpackage : acdpc_pkg

`default_nettype wire

/* rtl/acdpc_divider.sv */
`default_nettype none

module acdpc_divider (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       run_in,
  input  wire logic [2:0] ratio_m1_in,
  input  wire logic       sync_in,
  input  wire logic       dcs_en_in,
  output logic            tick_out,
  output logic            div_clk_out
);
  import acdpc_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
    logic       dclk;
  } acdpc_div_t;

  acdpc_div_t st_r;
  acdpc_div_t st_nxt;

  function automatic logic [3:0] high_len(input logic [2:0] m1);
    high_len = ({1'b0, m1} + 4'h2) >> 1;
  endfunction

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!run_in) begin
      st_nxt.cnt  = 3'h0;
      st_nxt.dclk = 1'b0;
    end else begin
      // ratio may shrink mid-period, so wrap on >= not ==
      if (sync_in || st_r.cnt >= ratio_m1_in) begin
        st_nxt.cnt = 3'h0;
      end else begin
        st_nxt.cnt = st_r.cnt + 3'h1;
      end
      st_nxt.tick = (st_nxt.cnt == 3'h0);
      // without the stabiliser the high time is just the raw one-cycle edge
      st_nxt.dclk = dcs_en_in ? ({1'b0, st_nxt.cnt} < high_len(ratio_m1_in))
                              : st_nxt.tick;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_out    = st_r.tick;
  assign div_clk_out = st_r.dclk;

  a_sync_realign: assert property (@(posedge clk_in) disable iff (rst_in)
    run_in && sync_in |=> st_r.cnt == 3'h0 && tick_out)
    else $error("sync did not return divider to its initial state");

  a_cnt_bound: assert property (@(posedge clk_in) disable iff (rst_in)
    run_in && $stable(ratio_m1_in) && st_r.cnt <= ratio_m1_in |=> st_r.cnt <= ratio_m1_in)
    else $error("divider count beyond selected ratio");

endmodule : acdpc_divider

`default_nettype wire

/* tb/acdpc_src_model.sv */
`default_nettype none

module acdpc_src_model (
  input  wire logic clk_in,
  input  wire logic ref_high_in,
  output logic      sync_out,
  output logic      ref_sel_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // sync driver and reference-select strap
  // ----------------------------------------------------------------
  logic drv_r = 1'b0;

  // released pin settles at the pull-down level, never a stale high
  assign sync_out    = drv_r;
  // strap is always driven to a level, never floating
  assign ref_sel_out = ref_high_in;

  // one-cycle pulse launched just after an edge
  task automatic pulse();
    drv_r = 1'b1;
    @(posedge clk_in);
    #1;
    drv_r = 1'b0;
  endtask
endmodule // acdpc_src_model

`default_nettype wire

/* tb/adc_clock_divider_power_ctrl_tb_top.sv */
`default_nettype none

module adc_clock_divider_power_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import acdpc_pkg::*;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic              clk      = 1'b0;
  logic              rst      = 1'b1;
  logic              pd_pin   = 1'b0;
  logic              ref_high = 1'b0;
  logic              wr       = 1'b0;
  logic              rd       = 1'b0;
  logic [ADDR_W-1:0] addr     = 12'h000;
  logic [DATA_W-1:0] wdata    = 8'h00;
  logic [DATA_W-1:0] rdata;
  logic              sync, ref_sel, rvalid, stb, div_clk, drv_en;
  logic              ref_pwr, bias_pwr, clk_pwr, int_ref, ready, lock;
  int                error_cnt   = 0;
  int                comparisons = 0;

  initial forever #4 clk = ~clk;

  acdpc_src_model src (
    .clk_in      (clk),
    .ref_high_in (ref_high),
    .sync_out    (sync),
    .ref_sel_out (ref_sel)
  );

  acdpc_ctrl dut (
    .CLK_IN                   (clk),
    .SYS_RST_IN               (rst),
    .SYNC_IN                  (sync),
    .POWERDOWN_PIN_IN         (pd_pin),
    .REF_SEL_HIGH_IN          (ref_sel),
    .REG_WR_IN                (wr),
    .REG_RD_IN                (rd),
    .REG_ADDR_IN              (addr),
    .REG_WDATA_IN             (wdata),
    .REG_RDATA_OUT            (rdata),
    .REG_RVALID_OUT           (rvalid),
    .SAMPLE_STB_OUT           (stb),
    .DIV_CLK_OUT              (div_clk),
    .OUT_DRV_EN_OUT           (drv_en),
    .REF_PWR_OUT              (ref_pwr),
    .BIAS_PWR_OUT             (bias_pwr),
    .CLK_PWR_OUT              (clk_pwr),
    .INT_REF_EN_OUT           (int_ref),
    .READY_OUT                (ready),
    .DUTY_STABILISER_LOCK_OUT (lock)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // inputs move 1 ns after the edge, away from the sampling point
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // idle edge after each access so a strobe never rises twice at once
  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    wr    = 1'b1;
    addr  = a;
    wdata = d;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask

  task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp);
    rd   = 1'b1;
    addr = a;
    tick(1);
    rd = 1'b0;
    chk(16'(rvalid), 16'h0001);
    chk(16'(rdata), 16'(exp));
    tick(1);
  endtask

  // sel: 0 strobe, 1 ready, 2 lock; quiet allows the bound to run out
  task automatic wait_for(input int sel, input int bound, input bit quiet, output int cnt);
    logic s;
    cnt = 0;
    do begin
      tick(1);
      cnt++;
      s = (sel == 0) ? stb : (sel == 1) ? ready : lock;
    end while (s !== 1'b1 && cnt < bound);
    if (s !== 1'b1 && !quiet) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  // divide by four; an accepted pulse strobes at the edge that sees the pin rise
  task automatic sync_try(input logic acc);
    int c;
    wait_for(0, 20, 1'b0, c);
    src.pulse();
    chk(16'(stb), 16'(acc));
    if (acc) begin
      chk(16'(div_clk), 16'h0001);
    end
    wait_for(0, 20, 1'b0, c);
    chk(16'(c), acc ? 16'h0004 : 16'h0003);
  endtask

  task automatic pd_cycle(input int hold, output int wake);
    pd_pin = 1'b1;
    tick(1);
    chk(16'({drv_en, ref_pwr, bias_pwr, clk_pwr, ready}), 16'h0000);
    tick(hold);
    pd_pin = 1'b0;
    tick(1);
    chk(16'({drv_en, ref_pwr, clk_pwr}), 16'h0007);
    wait_for(1, 5000, 1'b0, wake);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int c, w1, w2, hi;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(2);
    chk(16'({ready, drv_en, ref_pwr, bias_pwr, clk_pwr}), 16'h001f);
    reg_rd(ADDR_POWER_MODE, 8'h00);
    reg_rd(ADDR_DIV_SYNC, 8'h00);
    reg_rd(ADDR_CLK_DIV, 8'h10);
    reg_wr(ADDR_CLK_DIV, 8'hff);
    reg_rd(ADDR_CLK_DIV, 8'h17);
    reg_wr(12'h0ff, 8'h55);
    reg_rd(12'h0ff, 8'h00);
    // every ratio: period of the divided clock, and its high time for ratios up to six
    for (int n = 1; n <= 8; n++) begin
      reg_wr(ADDR_CLK_DIV, 8'h10 | 8'(n - 1));
      wait_for(0, 20, 1'b0, c);
      hi = 0;
      for (int i = 0; i < n; i++) begin
        hi += int'(div_clk === 1'b1);
        tick(1);
      end
      chk(16'(stb), 16'h0001);
      if (n <= 6) begin
        chk(16'(hi), 16'((n + 1) / 2));
      end
    end
    reg_wr(ADDR_CLK_DIV, 8'h03);
    wait_for(0, 20, 1'b0, c);
    hi = 0;
    for (int i = 0; i < 4; i++) begin
      hi += int'(div_clk === 1'b1);
      tick(1);
    end
    chk(16'(hi), 16'h0001);
    // source waits out relock before relying on the clock
    reg_wr(ADDR_CLK_DIV, 8'h13);
    wait_for(2, 700, 1'b0, c);
    chk(16'(c > 600), 16'h0001);
    reg_wr(ADDR_CLK_DIV, 8'h17);
    wait_for(2, 700, 1'b1, c);
    chk(16'(lock), 16'h0000);
    reg_wr(ADDR_CLK_DIV, 8'h13);
    reg_wr(ADDR_DIV_SYNC, 8'h00);
    sync_try(1'b0);
    reg_wr(ADDR_DIV_SYNC, 8'h01);
    sync_try(1'b1);
    sync_try(1'b1);
    reg_wr(ADDR_DIV_SYNC, 8'h03);
    reg_rd(ADDR_DIV_SYNC, 8'h0b);
    sync_try(1'b1);
    reg_rd(ADDR_DIV_SYNC, 8'h03);
    sync_try(1'b0);
    pd_cycle(32, w1);
    pd_cycle(320, w2);
    chk(16'(w2 > w1), 16'h0001);
    reg_wr(ADDR_POWER_MODE, 8'h01);
    tick(1);
    chk(16'({drv_en, ref_pwr, clk_pwr, ready}), 16'h0000);
    reg_wr(ADDR_POWER_MODE, 8'h00);
    wait_for(1, 5000, 1'b0, c);
    reg_wr(ADDR_POWER_MODE, 8'h02);
    tick(1);
    chk(16'({ref_pwr, bias_pwr, ready}), 16'h0004);
    reg_wr(ADDR_POWER_MODE, 8'h00);
    wait_for(1, 5000, 1'b0, c);
    for (int m = 3; m <= 7; m++) begin
      reg_wr(ADDR_POWER_MODE, 8'(m));
      tick(1);
      chk(16'(ready), 16'h0001);
    end
    ref_high = 1'b1;
    tick(2);
    chk(16'(int_ref), 16'h0000);
    ref_high = 1'b0;
    tick(2);
    chk(16'(int_ref), 16'h0001);
    report_and_stop();
  end
endmodule // adc_clock_divider_power_ctrl_tb_top

`default_nettype wire
